// File: src/mhs_header_seq.sv
// Message header sequencer: fourteen-character header generator.
// Assumes step_pulse comes from sequence-control logic on pclk, one
// cycle wide, and APB from a master on the same clock.
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "mhs_consts.svh"

module mhs_header_seq
   import mhs_pkg::*;
#(
   parameter logic [`MHS_TMR_W-1:0] SETTLE_CYCLES =
      `MHS_TMR_W'(`MHS_SETTLE_CYC)
) (
   input wire logic pclk, // System clock, 20 MHz
   input wire logic presetn, // Async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB direction, high for write
   input wire logic [31:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error, unmapped address
   input wire logic step_pulse, // Header step from sequence control
   output logic [7:0] char_levels_q, // Levels one to eight, 1 = mark
   output logic header_out_en_q, // Header output gates primed
   output logic message_header_active_q, // Header sequence running
   output logic display_step_relay_q, // Number display stepping drive
   output logic verifier_alarm_inhibit_q, // Suppress verifier alarm
   output logic reader_gate_block_q, // Block reader data sampling
   output logic serial_converter_switch_en_q, // Converter switch enable
   output logic header_complete_q, // Header finished, to reader logic
   output logic reader_step_q, // Fifteenth step pulse, the one that resets the counter, routed to the reader
   output logic [13:0] select_q, // Count select, bit 0 is count one
   output logic reset_detect_q // Counter in reset state
);

   ////////////////////////////////////////////////////////////////////
   // Decode and character functions

   function automatic logic [`MHS_SEL_W-1:0] sel_of(
      input logic [`MHS_CNT_W-1:0] cnt
   );
      logic [`MHS_SEL_W-1:0] s;
      s = '0;
      if (cnt != `MHS_CNT_CLEAR && cnt <= `MHS_LAST_COUNT) begin
         s[cnt - `MHS_CNT_ONE] = 1'b1;
      end
      return s;
   endfunction

   function automatic logic [4:0] code_of(
      input logic [`MHS_CNT_W-1:0] cnt,
      input logic [4:0] oper,
      input logic [14:0] num
   );
      logic [4:0] c;
      case (cnt)
         `MHS_CNT_V: c = `MHS_CODE_V;
         `MHS_CNT_Z: c = `MHS_CODE_Z;
         `MHS_CNT_C3: c = `MHS_CODE_C3;
         `MHS_CNT_C4: c = `MHS_CODE_C4;
         `MHS_CNT_C5: c = `MHS_CODE_C5;
         `MHS_CNT_C6: c = `MHS_CODE_C6;
         `MHS_CNT_C7: c = `MHS_CODE_C7;
         `MHS_CNT_C8: c = `MHS_CODE_C8;
         `MHS_CNT_OPER: c = oper;
         `MHS_CNT_FIGS: c = `MHS_CODE_FIGS;
         `MHS_CNT_DIG0: c = num[4:0];
         `MHS_CNT_DIG1: c = num[9:5];
         `MHS_CNT_DIG2: c = num[14:10];
         `MHS_LAST_COUNT: c = `MHS_CODE_LTRS;
         default: c = `MHS_CODE_SPACE;
      endcase
      return c;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Registers and wires

   mhs_phase_t phase_q;
   mhs_phase_t phase_d;
   logic [`MHS_CNT_W-1:0] count_q;
   logic [`MHS_CNT_W-1:0] count_d;
   logic [4:0] opsel_q;
   logic [14:0] msgnum_q;
   logic holdoff_busy;
   logic step_ok;
   logic step_adv;
   logic step_last;
   logic into_reset;
   logic active_d;
   logic [4:0] code_d;
   logic [7:0] char_d;
   logic apb_setup;
   logic apb_wr;
   logic hit_opsel;
   logic hit_msgnum;
   logic hit_status;
   logic hit_any;
   logic [31:0] rdata_d;

   ////////////////////////////////////////////////////////////////////
   // Step routing and counter

   // Steps are dropped while the display mechanism settles
   assign step_ok = step_pulse && !holdoff_busy;
   // Once the completion latch is set, counting stops
   assign step_adv = step_ok && (phase_q == MHS_PH_IDLE ||
      phase_q == MHS_PH_RUN);
   assign step_last = step_ok && (phase_q == MHS_PH_DONE);

   assign count_d = step_last ? `MHS_CNT_CLEAR :
      step_adv ? count_q + `MHS_CNT_ONE : count_q;

   // Only the edge into reset fires the hold-off
   assign into_reset = (count_q != `MHS_CNT_CLEAR) &&
      (count_d == `MHS_CNT_CLEAR);

   always_comb begin
      phase_d = phase_q;
      case (phase_q)
         MHS_PH_IDLE: begin
            if (step_adv) begin
               phase_d = MHS_PH_RUN;
            end
         end
         MHS_PH_RUN: begin
            if (count_d == `MHS_LAST_COUNT) begin
               phase_d = MHS_PH_DONE;
            end
         end
         MHS_PH_DONE: begin
            if (step_last) begin
               phase_d = MHS_PH_SETTLE;
            end
         end
         MHS_PH_SETTLE: begin
            if (!holdoff_busy) begin
               phase_d = MHS_PH_IDLE;
            end
         end
         default: phase_d = MHS_PH_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_q <= MHS_PH_IDLE;
         count_q <= `MHS_CNT_CLEAR;
      end else begin
         phase_q <= phase_d;
         count_q <= count_d;
      end
   end

   mhs_settle_timer #(
      .CYCLES(SETTLE_CYCLES)
   ) u_settle (
      .pclk(pclk),
      .presetn(presetn),
      .start(into_reset),
      .busy_q(holdoff_busy)
   );

   ////////////////////////////////////////////////////////////////////
   // Character and control outputs

   // Outputs follow the next count so they line up with count_q
   assign active_d = (count_d != `MHS_CNT_CLEAR);
   assign code_d = code_of(count_d, opsel_q, msgnum_q);
   // Five-level header: levels one, seven and eight stay spacing
   assign char_d = active_d ? {2'b00, code_d, 1'b0} : 8'h00;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         char_levels_q <= 8'h00;
         header_out_en_q <= 1'b0;
         message_header_active_q <= 1'b0;
         display_step_relay_q <= 1'b0;
         verifier_alarm_inhibit_q <= 1'b0;
         reader_gate_block_q <= 1'b0;
         serial_converter_switch_en_q <= 1'b1;
         header_complete_q <= 1'b0;
         reader_step_q <= 1'b0;
         select_q <= '0;
         reset_detect_q <= 1'b1;
      end else begin
         char_levels_q <= char_d;
         header_out_en_q <= active_d;
         message_header_active_q <= active_d;
         display_step_relay_q <= active_d;
         verifier_alarm_inhibit_q <= active_d;
         reader_gate_block_q <= active_d;
         serial_converter_switch_en_q <= !active_d;
         header_complete_q <= (count_d == `MHS_LAST_COUNT);
         reader_step_q <= step_last;
         select_q <= sel_of(count_d);
         reset_detect_q <= !active_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // APB slave, zero wait states

   assign apb_setup = psel && !penable;
   assign apb_wr = psel && penable && pready && pwrite;
   assign hit_opsel = (paddr[`MHS_ADDR_W-1:0] == `MHS_OFF_OPSEL);
   assign hit_msgnum = (paddr[`MHS_ADDR_W-1:0] == `MHS_OFF_MSGNUM);
   assign hit_status = (paddr[`MHS_ADDR_W-1:0] == `MHS_OFF_STATUS);
   assign hit_any = hit_opsel || hit_msgnum || hit_status;

   assign rdata_d = hit_opsel ? {27'h000_0000, opsel_q} :
      hit_msgnum ? {17'h0_0000, msgnum_q} :
      hit_status ? {24'h00_0000, message_header_active_q,
         holdoff_busy, phase_q, count_q} : 32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= apb_setup;
         pslverr <= apb_setup && !hit_any;
         prdata <= (apb_setup && !pwrite) ? rdata_d : 32'h0000_0000;
      end
   end

   // Switch settings may change mid-header; the new value is used from
   // the next clock on, even within the current count, as a real switch would be
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opsel_q <= `MHS_OPSEL_RST;
         msgnum_q <= `MHS_MSGNUM_RST;
      end else begin
         if (apb_wr && hit_opsel) begin
            opsel_q <= pwdata[4:0];
         end
         if (apb_wr && hit_msgnum) begin
            msgnum_q <= pwdata[14:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_counting;
      step_adv && count_q < `MHS_LAST_COUNT;
   endsequence

   sequence s_fifteenth;
      phase_q == MHS_PH_DONE && step_pulse && !holdoff_busy;
   endsequence

   count_step_a: assert property (
      s_counting |=> count_q == $past(count_q) + `MHS_CNT_ONE)
      else $error("counter did not advance on step");

   count_limit_a: assert property (
      count_q <= `MHS_LAST_COUNT)
      else $error("counter passed fourteen");

   sel_onehot_a: assert property (
      (count_q != `MHS_CNT_CLEAR) |->
      select_q == sel_of(count_q) && $onehot(select_q) && !reset_detect_q)
      else $error("select does not match count");

   relay_hold_a: assert property (
      (count_q != `MHS_CNT_CLEAR) |->
      message_header_active_q && display_step_relay_q)
      else $error("relay or active dropped mid header");

   relay_drop_a: assert property (
      $fell(display_step_relay_q) |-> count_q == `MHS_CNT_CLEAR)
      else $error("relay released away from reset");

   reader_block_a: assert property (
      message_header_active_q |->
      verifier_alarm_inhibit_q && reader_gate_block_q)
      else $error("reader path open during header");

   conv_switch_a: assert property (
      serial_converter_switch_en_q == !message_header_active_q)
      else $error("converter switch enable wrong");

   out_gate_a: assert property (
      !header_out_en_q |-> char_levels_q == 8'h00)
      else $error("header character outside sequence");

   holdoff_start_a: assert property (
      s_fifteenth |=> holdoff_busy && !step_adv [*2])
      else $error("hold-off not started at reset");

   holdoff_only_a: assert property (
      $rose(holdoff_busy) |->
      $past(count_q) != `MHS_CNT_CLEAR && count_q == `MHS_CNT_CLEAR)
      else $error("hold-off fired on wrong edge");

   char_v_a: assert property (
      count_q == `MHS_CNT_V |->
      char_levels_q == {2'b00, `MHS_CODE_V, 1'b0})
      else $error("count one is not V");

   char_z_a: assert property (
      count_q == `MHS_CNT_Z |->
      char_levels_q == {2'b00, `MHS_CODE_Z, 1'b0})
      else $error("count two is not Z");

   last_char_a: assert property (
      count_q == `MHS_LAST_COUNT |-> header_complete_q &&
      char_levels_q == {2'b00, `MHS_CODE_LTRS, 1'b0})
      else $error("count fourteen wrong");

   reset_pulse_a: assert property (
      s_fifteenth |=> count_q == `MHS_CNT_CLEAR && reader_step_q
      ##1 !reader_step_q)
      else $error("fifteenth step did not reset counter");

   unused_lvl_a: assert property (
      char_levels_q[0] == 1'b0 && char_levels_q[7:6] == 2'b00)
      else $error("level one, seven or eight marked");

endmodule

// File: common/mhs_consts.svh
// Constants for the message header sequencer: register map, character
// codes and timing.
// Assumes inclusion by bare name from design and bench files.
`ifndef MHS_CONSTS_SVH
`define MHS_CONSTS_SVH

// Register byte offsets within the 4 KiB APB window
`define MHS_OFF_OPSEL 12'h000
`define MHS_OFF_MSGNUM 12'h004
`define MHS_OFF_STATUS 12'h008
`define MHS_ADDR_W 12

// Reset values of the writable registers
`define MHS_OPSEL_RST 5'h00
`define MHS_MSGNUM_RST 15'h0000

// Counter figures
`define MHS_CNT_W 4
`define MHS_CNT_CLEAR 4'h0
`define MHS_CNT_ONE 4'h1
`define MHS_LAST_COUNT 4'hE
`define MHS_SEL_W 14

// Header counts with a fixed meaning
`define MHS_CNT_V 4'h1
`define MHS_CNT_Z 4'h2
`define MHS_CNT_OPER 4'h9
`define MHS_CNT_FIGS 4'hA
`define MHS_CNT_DIG0 4'hB
`define MHS_CNT_DIG1 4'hC
`define MHS_CNT_DIG2 4'hD
`define MHS_CNT_C3 4'h3
`define MHS_CNT_C4 4'h4
`define MHS_CNT_C5 4'h5
`define MHS_CNT_C6 4'h6
`define MHS_CNT_C7 4'h7
`define MHS_CNT_C8 4'h8

// Five-level codes, bit 0 is level two and bit 4 is level six; 1 = mark
`define MHS_CODE_V 5'h1E
`define MHS_CODE_Z 5'h11
`define MHS_CODE_FIGS 5'h1B
`define MHS_CODE_LTRS 5'h1F
`define MHS_CODE_SPACE 5'h00

// Fixed characters for counts three to eight
`define MHS_CODE_C3 5'h01
`define MHS_CODE_C4 5'h02
`define MHS_CODE_C5 5'h04
`define MHS_CODE_C6 5'h08
`define MHS_CODE_C7 5'h10
`define MHS_CODE_C8 5'h03

// Field layout of the digit register
`define MHS_DIG_W 5

// Timing: display settle hold-off
`define MHS_SETTLE_MS 225
`define MHS_CLK_KHZ 20000
`define MHS_SETTLE_CYC (`MHS_SETTLE_MS * `MHS_CLK_KHZ)
`define MHS_TMR_W 23

`endif

// File: common/mhs_pkg.sv
// Types shared by the message header sequencer files.
// Assumes nothing of its surroundings.
package mhs_pkg;

   // Phase of one header; Gray coded along idle, run, done, settle
   typedef enum logic [1:0] {
      MHS_PH_IDLE = 2'b00,
      MHS_PH_RUN = 2'b01,
      MHS_PH_DONE = 2'b11,
      MHS_PH_SETTLE = 2'b10
   } mhs_phase_t;

endpackage

// File: src/mhs_settle_timer.sv
// Display settle hold-off timer.
// Assumes start is a single-cycle pulse on the pclk domain.
`timescale 1ns/1ps
`include "mhs_consts.svh"

module mhs_settle_timer #(
   parameter logic [`MHS_TMR_W-1:0] CYCLES = `MHS_TMR_W'(`MHS_SETTLE_CYC)
) (
   input wire logic pclk, // System clock
   input wire logic presetn, // Async reset, active low
   input wire logic start, // Begin a hold-off
   output logic busy_q // Hold-off running
);

   logic [`MHS_TMR_W-1:0] left_q;
   logic [`MHS_TMR_W-1:0] left_d;
   logic busy_d;

   // A fresh start restarts the full period
   assign left_d = start ? CYCLES :
      (left_q != '0) ? left_q - `MHS_TMR_W'(1) : left_q;
   assign busy_d = (left_d != '0);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         left_q <= '0;
         busy_q <= 1'b0;
      end else begin
         left_q <= left_d;
         busy_q <= busy_d;
      end
   end

endmodule

// File: tb/mhs_seq_ctrl_model.sv
// Sequence-control model: issues a burst of header step pulses.
// Assumes pclk and presetn of the sequencer; commands from the bench.
`timescale 1ns/1ps

module mhs_seq_ctrl_model (
   input wire logic pclk, // System clock
   input wire logic presetn, // Async reset, active low
   input wire logic start, // Load a new burst
   input wire logic [4:0] n_steps, // Steps in the burst
   input wire logic [3:0] gap, // Idle cycles between steps
   output logic step_pulse, // One-cycle header step
   output logic busy // Burst in progress
);
   logic [4:0] left_q;
   logic [3:0] wait_q;

   ////////////////////////////////////////////////////////////////////
   // One pulse per character interval, spacing set by the bench
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         left_q <= 5'h00;
         wait_q <= 4'h0;
         step_pulse <= 1'b0;
      end else begin
         step_pulse <= 1'b0;
         if (start) begin
            left_q <= n_steps;
            wait_q <= 4'h0;
         end else if (left_q != 5'h00) begin
            if (wait_q == 4'h0) begin
               step_pulse <= 1'b1;
               left_q <= left_q - 5'h01;
               wait_q <= gap;
            end else begin
               wait_q <= wait_q - 4'h1;
            end
         end
      end
   end

   // Pulse still in flight counts as busy so the bench sees it land
   assign busy = start || (left_q != 5'h00) || step_pulse;
endmodule

// File: tb/test_message_header_sequencer.sv
// Self-checking bench for the message header sequencer.
// Assumes the sequencer's APB answers with pready and a short hold-off.
`timescale 1ns/1ps
`include "mhs_consts.svh"

module test_message_header_sequencer;
   localparam int SETTLE = 20;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0000_0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, step_pulse, seq_busy;
   logic seq_start = 1'b0;
   logic [4:0] seq_steps = 5'h00;
   logic [3:0] seq_gap = 4'h1;
   logic [7:0] char_levels_q;
   logic [13:0] select_q;
   logic [13:0] sel_prev = 14'h0000;
   logic hdr_en, active, relay, alarm_inh, gate_blk, conv_en, done;
   logic rd_step, rst_det;
   logic [33:0] rdq[$];
   logic [11:0] chq[$];
   logic [33:0] r;
   logic [11:0] c;
   logic [3:0] cnt_v = 4'h0;
   logic [4:0] opsel_v = 5'h00;
   logic [14:0] msg_v = 15'h0000;
   logic [31:0] w;
   int failures = 0;
   int samples_checked = 0;

   always #25 pclk = ~pclk;

   mhs_header_seq #(.SETTLE_CYCLES(23'(SETTLE))) dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .step_pulse(step_pulse),
      .char_levels_q(char_levels_q), .header_out_en_q(hdr_en),
      .message_header_active_q(active), .display_step_relay_q(relay),
      .verifier_alarm_inhibit_q(alarm_inh), .reader_gate_block_q(gate_blk),
      .serial_converter_switch_en_q(conv_en), .header_complete_q(done),
      .reader_step_q(rd_step), .select_q(select_q),
      .reset_detect_q(rst_det));

   mhs_seq_ctrl_model seq (.pclk(pclk), .presetn(presetn),
      .start(seq_start), .n_steps(seq_steps), .gap(seq_gap),
      .step_pulse(step_pulse), .busy(seq_busy));

   ////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude;
      $display("Checks %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   function automatic logic [7:0] exp_char(input logic [3:0] n);
      logic [4:0] k;
      case (n)
         4'h1: k = `MHS_CODE_V;
         4'h2: k = `MHS_CODE_Z;
         4'h3: k = `MHS_CODE_C3;
         4'h4: k = `MHS_CODE_C4;
         4'h5: k = `MHS_CODE_C5;
         4'h6: k = `MHS_CODE_C6;
         4'h7: k = `MHS_CODE_C7;
         4'h8: k = `MHS_CODE_C8;
         4'h9: k = opsel_v;
         4'hA: k = `MHS_CODE_FIGS;
         4'hB: k = msg_v[4:0];
         4'hC: k = msg_v[9:5];
         4'hD: k = msg_v[14:10];
         4'hE: k = `MHS_CODE_LTRS;
         default: k = 5'h00;
      endcase
      // Levels one, seven and eight never mark in a header
      return {2'b00, k, 1'b0};
   endfunction

   // Holds the request until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [31:0] a, d, e,
                      input logic err);
      int t;
      rdq.push_back({wr, err, e});
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      t = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && t < 50) begin
         @(posedge pclk);
         t++;
      end
      // A slave that never answers counts against the run
      if (t >= 50) failures++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Queue the expected characters, then let the model send the steps
   task automatic hdr(input int n, input int g, input bit note);
      int t;
      if (note) for (int k = 0; k < n; k++) begin
         cnt_v = (cnt_v == 4'hE) ? 4'h0 : cnt_v + 4'h1;
         chq.push_back({cnt_v, exp_char(cnt_v)});
      end
      @(posedge pclk);
      seq_start <= 1'b1;
      seq_steps <= 5'(n);
      seq_gap <= 4'(g);
      @(posedge pclk);
      seq_start <= 1'b0;
      t = 0;
      while (seq_busy === 1'b1 && t < 400) begin
         @(posedge pclk);
         t++;
      end
      if (t >= 400) failures++;
   endtask

   ////////////////////////////////////////////////////////////////////
   always @(negedge pclk) begin
      if (presetn) begin
         if (psel && penable && pready === 1'b1) begin
            if (rdq.size() == 0) chk(32'h1, 32'h0);
            else begin
               r = rdq.pop_front();
               chk(32'(pslverr), 32'(r[32]));
               if (!r[33]) chk(prdata, r[31:0]);
            end
         end
         if (select_q !== sel_prev) begin
            if (chq.size() == 0) chk(32'(select_q), 32'(sel_prev));
            else begin
               c = chq.pop_front();
               chk(32'(select_q), (c[11:8] == 4'h0) ? 32'h0 :
                   32'h1 << (c[11:8] - 4'h1));
               chk(32'(char_levels_q), 32'(c[7:0]));
               chk(32'(rst_det), 32'(c[11:8] == 4'h0));
               chk(32'({active, relay}), {30'h0, {2{c[11:8] != 4'h0}}});
               chk(32'({alarm_inh, gate_blk}),
                   {30'h0, {2{c[11:8] != 4'h0}}});
               chk(32'(conv_en), 32'(c[11:8] == 4'h0));
               chk(32'(hdr_en), 32'(c[11:8] != 4'h0));
               chk(32'(done), 32'(c[11:8] == 4'hE));
               chk(32'(rd_step), 32'(c[11:8] == 4'h0));
            end
         end else begin
            chk(32'(rd_step), 32'h0);
         end
         sel_prev = select_q;
      end
   end

   initial begin
      #(4000 * 50);
      failures++;
      conclude();
   end

   initial begin
      void'($urandom(32'h05bf));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 32'h0000_0000, 32'h0, 32'h0, 1'b0);
      apb(1'b0, 32'h0000_0004, 32'h0, 32'h0, 1'b0);
      apb(1'b0, 32'h0000_0008, 32'h0, 32'h0, 1'b0);
      apb(1'b1, 32'h0000_0010, 32'h5, 32'h0, 1'b1);
      apb(1'b0, 32'h0000_0FFC, 32'h0, 32'h0, 1'b1);
      apb(1'b1, 32'h0000_0008, 32'hFFFF_FFFF, 32'h0, 1'b0);
      apb(1'b0, 32'h0000_0008, 32'h0, 32'h0, 1'b0);
      apb(1'b1, 32'h0000_0000, 32'hFFFF_FFFF, 32'h0, 1'b0);
      apb(1'b0, 32'h0000_0000, 32'h0, 32'h0000_001F, 1'b0);
      for (int h = 0; h < 2; h++) begin
         w = $urandom();
         opsel_v = w[4:0];
         apb(1'b1, 32'h0000_0000, w, 32'h0, 1'b0);
         apb(1'b0, 32'h0000_0000, 32'h0, {27'h0, opsel_v}, 1'b0);
         w = $urandom();
         msg_v = w[14:0];
         apb(1'b1, 32'h0000_0004, w, 32'h0, 1'b0);
         apb(1'b0, 32'h0000_0004, 32'h0, {17'h0, msg_v}, 1'b0);
         hdr(15, 1 + h * 3, 1'b1);
         // Steps inside the hold-off must leave the count alone
         hdr(2, 1, 1'b0);
         apb(1'b0, 32'h0000_0008, 32'h0, 32'h0000_0060, 1'b0);
         repeat (SETTLE + 5) @(posedge pclk);
         apb(1'b0, 32'h0000_0008, 32'h0, 32'h0, 1'b0);
      end
      chk(32'(chq.size()), 32'h0);
      chk(32'(rdq.size()), 32'h0);
      conclude();
   end
endmodule
